// file: rtl/acs_ctrl.sv
`timescale 1ns/1ns
`include "acs_defs.svh"
// Notes on behaviour
// - conversion takes exactly twenty master clocks
// - busy rises within 2.5 clocks after calibrate
// - start during calibration is ignored, busy unchanged
// - full self calibration lasts 250026 clocks
// - reference plus full-scale calibration 222228 clocks
// - offset calibration lasts 27798 clocks
// - data out driven only while frame low
// - output bits launched on falling serial clock
// - written bits sampled on rising serial clock
// - shared data-in line turns, then releases
module acs_ctrl
    import acs_pkg::*;
#(
    parameter int CAL_FULL_CYC  = `ACS_CAL_FULL,
    parameter int CAL_DACFS_CYC = `ACS_CAL_DACFS,
    parameter int CAL_OFFS_CYC  = `ACS_CAL_OFFS
) (
    input  wire logic        core_clk_i,        // master clock
    input  wire logic        rst_i,             // sync reset, high
    input  wire logic        conversion_start_n_i, // start pin, low
    input  wire logic        cal_n_i,           // calibrate pin, low
    input  wire logic [1:0]  cal_sel_i,         // calibration kind
    input  wire logic [13:0] sample_i,          // converted value
    input  wire logic        din_shared_i,      // data-in line shared
    output logic             busy_o,            // busy flag
    output logic             conv_refused_o,    // buffer full at start
    output acs_pmode_t       power_mode_o,      // power mode bits
    output logic             power_down_o,      // any power-down
    input  wire logic        link_sclk_i,       // serial clock
    input  wire logic        frame_n_i,         // frame select, low
    input  wire logic        din_i,             // data-in line level
    output logic             din_o,             // data-in line drive
    output logic             din_oe_n_o,        // low while driving
    output logic             dout_o,            // serial data out
    output logic             dout_oe_n_o        // low while driving
);
    localparam int CW = 18;

    // ---------------- core domain ----------------
    logic [1:0]  conv_sy_r, conv_sy_nxt;
    logic [1:0]  cal_sy_r, cal_sy_nxt;
    logic        conv_prev_r, conv_prev_nxt;
    logic        cal_prev_r, cal_prev_nxt;
    acs_state_t  state_r, state_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic        conv_fall, cal_fall;
    logic        push, in_ready, out_valid, pop;
    logic [13:0] res_mem [2];
    logic [13:0] res_mem_nxt [2];
    logic        wp_r, wp_nxt, rp_r, rp_nxt;
    logic [1:0]  fill_r, fill_nxt;
    logic [13:0] xfer_r, xfer_nxt;
    logic        offer_r, offer_nxt;
    logic [1:0]  ack_sy_r, ack_sy_nxt;
    logic [1:0]  wtg_sy_r, wtg_sy_nxt;
    logic        wtg_seen_r, wtg_seen_nxt;
    acs_pmode_t  pm_r, pm_nxt;
    logic        refused_r, refused_nxt;
    logic [1:0]  sel_sy0_r, sel_sy0_nxt, sel_sy1_r, sel_sy1_nxt;

    // ---------------- link domain ----------------
    logic [1:0]  lrst_sy_r;
    logic        lrst;
    logic [1:0]  shr_sy_r;
    logic [4:0]  rx_cnt_r, rx_cnt_nxt;
    logic [15:0] rx_sh_r, rx_sh_nxt;
    logic [15:0] wword_r, wword_nxt;
    logic        wtg_r, wtg_nxt;
    logic        turn_r, turn_nxt;
    logic [1:0]  offer_sy_r, offer_sy_nxt;
    logic        ack_r, ack_nxt;
    logic [4:0]  tx_cnt_r, tx_cnt_nxt;
    logic [15:0] tx_sh_r, tx_sh_nxt;
    logic        stat_r, stat_nxt;

    assign conv_fall = conv_prev_r & ~conv_sy_r[1];
    assign cal_fall  = cal_prev_r & ~cal_sy_r[1];
    assign in_ready  = (fill_r != 2'h2);
    assign out_valid = (fill_r != 2'h0);
    assign pop       = out_valid & (offer_r == ack_sy_r[1]);
    assign push      = (state_r == ACS_CONV) & (cnt_r == '0);

    function automatic logic [CW-1:0] cal_len(input logic [1:0] sel);
        case (sel)
            `ACS_CAL_SEL_DACFS: cal_len = CW'(CAL_DACFS_CYC - 1);
            `ACS_CAL_SEL_OFFS:  cal_len = CW'(CAL_OFFS_CYC - 1);
            default:            cal_len = CW'(CAL_FULL_CYC - 1);
        endcase
    endfunction

    always_comb begin
        conv_sy_nxt   = {conv_sy_r[0], conversion_start_n_i};
        cal_sy_nxt    = {cal_sy_r[0], cal_n_i};
        conv_prev_nxt = conv_sy_r[1];
        cal_prev_nxt  = cal_sy_r[1];
        sel_sy0_nxt   = cal_sel_i;
        sel_sy1_nxt   = sel_sy0_r;
        state_nxt     = state_r;
        cnt_nxt       = cnt_r;
        refused_nxt   = 1'b0;
        case (state_r)
            ACS_IDLE: begin
                if (cal_fall) begin
                    state_nxt = ACS_CAL;
                    // kind passes the same two stages as the pin
                    cnt_nxt   = cal_len(sel_sy1_r);
                end else if (conv_fall && !power_down_o) begin
                    // a full buffer refuses the start, so no word is lost
                    if (in_ready) begin
                        state_nxt = ACS_CONV;
                        cnt_nxt   = CW'(`ACS_CONV_CYC - 1);
                    end else begin
                        refused_nxt = 1'b1;
                    end
                end
            end
            ACS_CONV, ACS_CAL: begin
                if (cnt_r == '0) begin
                    state_nxt = ACS_IDLE;
                end else begin
                    cnt_nxt = cnt_r - CW'(1);
                end
            end
            default: state_nxt = ACS_IDLE;
        endcase
    end

    // busy also follows the detected edge itself so it rises in two clocks
    assign busy_o = (state_r != ACS_IDLE)
                  | (state_r == ACS_IDLE & cal_fall)
                  | (state_r == ACS_IDLE & conv_fall & in_ready
                     & !power_down_o);
    assign conv_refused_o = refused_r;
    assign power_mode_o   = pm_r;
    assign power_down_o   = pm_r.power_mode_hi_bit;

    // two-entry result buffer and toggle hand-off toward the link
    always_comb begin
        res_mem_nxt = res_mem;
        wp_nxt      = wp_r;
        rp_nxt      = rp_r;
        fill_nxt    = fill_r;
        xfer_nxt    = xfer_r;
        offer_nxt   = offer_r;
        ack_sy_nxt  = {ack_sy_r[0], ack_r};
        if (push) begin
            res_mem_nxt[wp_r] = sample_i;
            wp_nxt = ~wp_r;
        end
        if (pop) begin
            xfer_nxt  = res_mem[rp_r];
            offer_nxt = ~offer_r;
            rp_nxt    = ~rp_r;
        end
        fill_nxt = fill_r + {1'b0, push} - {1'b0, pop};
    end

    // written word crosses by toggle; the word is stable until the last bit of the next frame's word
    always_comb begin
        wtg_sy_nxt   = {wtg_sy_r[0], wtg_r};
        wtg_seen_nxt = wtg_sy_r[1];
        pm_nxt       = pm_r;
        if (wtg_sy_r[1] != wtg_seen_r) begin
            pm_nxt.power_mode_hi_bit = wword_r[`ACS_BIT_PMHI];
            pm_nxt.power_mode_lo_bit = wword_r[`ACS_BIT_PMLO];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            conv_sy_r   <= 2'h3;
            cal_sy_r    <= 2'h3;
            conv_prev_r <= 1'b1;
            cal_prev_r  <= 1'b1;
            sel_sy0_r   <= 2'h0;
            sel_sy1_r   <= 2'h0;
            state_r     <= ACS_IDLE;
            cnt_r       <= '0;
            refused_r   <= 1'b0;
            wp_r        <= 1'b0;
            rp_r        <= 1'b0;
            fill_r      <= 2'h0;
            xfer_r      <= 14'h0000;
            offer_r     <= 1'b0;
            ack_sy_r    <= 2'h0;
            wtg_sy_r    <= 2'h0;
            wtg_seen_r  <= 1'b0;
            pm_r        <= '0;
            res_mem[0]  <= 14'h0000;
            res_mem[1]  <= 14'h0000;
        end else begin
            conv_sy_r   <= conv_sy_nxt;
            cal_sy_r    <= cal_sy_nxt;
            conv_prev_r <= conv_prev_nxt;
            cal_prev_r  <= cal_prev_nxt;
            sel_sy0_r   <= sel_sy0_nxt;
            sel_sy1_r   <= sel_sy1_nxt;
            state_r     <= state_nxt;
            cnt_r       <= cnt_nxt;
            refused_r   <= refused_nxt;
            wp_r        <= wp_nxt;
            rp_r        <= rp_nxt;
            fill_r      <= fill_nxt;
            xfer_r      <= xfer_nxt;
            offer_r     <= offer_nxt;
            ack_sy_r    <= ack_sy_nxt;
            wtg_sy_r    <= wtg_sy_nxt;
            wtg_seen_r  <= wtg_seen_nxt;
            pm_r        <= pm_nxt;
            res_mem     <= res_mem_nxt;
        end
    end

    // ---------------- link logic ----------------
    // reset reaches the link only while the serial clock runs
    always_ff @(posedge link_sclk_i) begin
        lrst_sy_r <= {lrst_sy_r[0], rst_i};
        shr_sy_r  <= {shr_sy_r[0], din_shared_i};
    end
    assign lrst = lrst_sy_r[1];

    always_comb begin
        rx_cnt_nxt = rx_cnt_r;
        rx_sh_nxt  = rx_sh_r;
        wword_nxt  = wword_r;
        wtg_nxt    = wtg_r;
        turn_nxt   = 1'b0;
        if (frame_n_i) begin
            rx_cnt_nxt = 5'h00;
        end else if (rx_cnt_r != 5'(`ACS_WORD_W)) begin
            rx_sh_nxt  = {rx_sh_r[14:0], din_i};
            rx_cnt_nxt = rx_cnt_r + 5'h01;
            if (rx_cnt_r == 5'(`ACS_WORD_W - 1)) begin
                wword_nxt = {rx_sh_r[14:0], din_i};
                wtg_nxt   = ~wtg_r;
            end
        end else begin
            // turnaround drive on every other period after the word, while the frame stays low
            turn_nxt   = shr_sy_r[1] & !turn_r;
        end
    end

    always_ff @(posedge link_sclk_i) begin
        if (lrst) begin
            rx_cnt_r <= 5'h00;
            rx_sh_r  <= 16'h0000;
            wword_r  <= 16'h0000;
            wtg_r    <= 1'b0;
            turn_r   <= 1'b0;
        end else begin
            rx_cnt_r <= rx_cnt_nxt;
            rx_sh_r  <= rx_sh_nxt;
            wword_r  <= wword_nxt;
            wtg_r    <= wtg_nxt;
            turn_r   <= turn_nxt;
        end
    end

    always_comb begin
        offer_sy_nxt = {offer_sy_r[0], offer_r};
        ack_nxt      = ack_r;
        tx_cnt_nxt   = tx_cnt_r;
        tx_sh_nxt    = tx_sh_r;
        stat_nxt     = stat_r;
        if (frame_n_i) begin
            tx_cnt_nxt = 5'h00;
        end else if (tx_cnt_r == 5'h00) begin
            // a fresh result if one is offered, else all zero
            tx_sh_nxt  = (offer_sy_r[1] != ack_r) ? {xfer_r, 2'h0}
                                                  : 16'h0000;
            ack_nxt    = offer_sy_r[1];
            stat_nxt   = (offer_sy_r[1] != ack_r);
            tx_cnt_nxt = 5'h01;
        end else begin
            tx_sh_nxt  = {tx_sh_r[14:0], 1'b0};
            if (tx_cnt_r != 5'(`ACS_WORD_W)) begin
                tx_cnt_nxt = tx_cnt_r + 5'h01;
            end
        end
    end

    always_ff @(negedge link_sclk_i) begin
        if (lrst) begin
            offer_sy_r <= 2'h0;
            ack_r      <= 1'b0;
            tx_cnt_r   <= 5'h00;
            tx_sh_r    <= 16'h0000;
            stat_r     <= 1'b0;
        end else begin
            offer_sy_r <= offer_sy_nxt;
            ack_r      <= ack_nxt;
            tx_cnt_r   <= tx_cnt_nxt;
            tx_sh_r    <= tx_sh_nxt;
            stat_r     <= stat_nxt;
        end
    end

    assign dout_o      = tx_sh_r[15];
    assign dout_oe_n_o = frame_n_i;
    assign din_o       = stat_r;
    assign din_oe_n_o  = frame_n_i | !turn_r;
endmodule

// file: shared/acs_defs.svh
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

`define ACS_CLK_NS      20
`define ACS_CONV_CYC    20
`define ACS_CAL_FULL    250026
`define ACS_CAL_DACFS   222228
`define ACS_CAL_OFFS    27798
`define ACS_WORD_W      16
`define ACS_RES_W       14
`define ACS_BIT_PMHI    1
`define ACS_BIT_PMLO    0
`define ACS_CAL_SEL_FULL  2'h0
`define ACS_CAL_SEL_DACFS 2'h1
`define ACS_CAL_SEL_OFFS  2'h2
`define ACS_DIN_TURN_BIT  5'h10

`endif

// file: shared/acs_pkg.sv
package acs_pkg;
    typedef enum logic [2:0] {
        ACS_IDLE = 3'h1,
        ACS_CONV = 3'h2,
        ACS_CAL  = 3'h4
    } acs_state_t;

    typedef struct packed {
        logic        power_mode_hi_bit;
        logic        power_mode_lo_bit;
    } acs_pmode_t;

    typedef struct packed {
        logic        valid;
        logic [13:0] data;
    } acs_res_t;
endpackage

// file: tb/acs_ctrl_properties.sv
`timescale 1ns/1ns
module acs_ctrl_properties
    import acs_pkg::*;
#(
    parameter int CAL_FULL_CYC  = 40,
    parameter int CAL_DACFS_CYC = 30,
    parameter int CAL_OFFS_CYC  = 20
) (
    input wire logic       core_clk_i,           // master clock
    input wire logic       rst_i,                // sync reset
    input wire logic       conversion_start_n_i, // start pin
    input wire logic       cal_n_i,              // calibrate pin
    input wire logic       din_shared_i,         // shared data-in
    input wire logic       frame_n_i,            // frame select
    input wire logic       busy_o,               // busy flag
    input wire logic       conv_refused_o,       // start refused
    input wire logic       power_down_o,         // power-down
    input wire acs_pmode_t power_mode_o,         // power bits
    input wire logic       din_oe_n_o,           // data-in drive
    input wire logic       dout_oe_n_o           // data-out drive
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic [17:0] busy_cnt_r;
    always_ff @(posedge core_clk_i)
        busy_cnt_r <= (rst_i || !busy_o) ? 18'h0 : busy_cnt_r + 18'h1;
    busy_len_a: assert property ($fell(busy_o) |-> busy_cnt_r == 18'h15
        || busy_cnt_r == CAL_FULL_CYC + 1 || busy_cnt_r == CAL_DACFS_CYC + 1
        || busy_cnt_r == CAL_OFFS_CYC + 1) else $error("busy length wrong");
    cal_busy_a: assert property ($fell(cal_n_i) && !power_down_o
        |-> ##[0:2] busy_o) else $error("busy late after calibrate");
    start_busy_a: assert property ($fell(conversion_start_n_i) && !busy_o
        && !power_down_o && cal_n_i |-> ##[0:3] (busy_o || conv_refused_o))
        else $error("busy late after start");
    cal_start_a: assert property (busy_o && $fell(conversion_start_n_i)
        |-> busy_o [*3]) else $error("busy dropped on start");
    busy_hold_a: assert property ($rose(busy_o) |-> busy_o [*8])
        else $error("busy too short");
    dout_oe_a: assert property (dout_oe_n_o == frame_n_i)
        else $error("data out drive outside frame");
    din_turn_a: assert property (!din_oe_n_o |-> !frame_n_i && din_shared_i)
        else $error("data-in driven wrongly");
    pd_map_a: assert property (power_down_o == power_mode_o.power_mode_hi_bit)
        else $error("power-down not from high bit");
    pd_quiet_a: assert property (power_down_o && !busy_o
        && $fell(conversion_start_n_i) |=> !busy_o [*3])
        else $error("start taken in power-down");
endmodule
bind acs_ctrl acs_ctrl_properties #(.CAL_FULL_CYC(CAL_FULL_CYC),
    .CAL_DACFS_CYC(CAL_DACFS_CYC), .CAL_OFFS_CYC(CAL_OFFS_CYC)) prop_u (
    .core_clk_i, .rst_i, .conversion_start_n_i, .cal_n_i, .din_shared_i,
    .frame_n_i, .busy_o, .conv_refused_o, .power_down_o,
    .power_mode_o, .din_oe_n_o,
    .dout_oe_n_o);

// file: tb/acs_host_model.sv
`timescale 1ns/1ns
module acs_host_model (
    input  wire logic din_o,       // device drive on data-in
    input  wire logic din_oe_n_o,  // low while device drives
    input  wire logic dout_o,      // serial data out
    output logic      link_sclk_i, // serial clock, 64 ns
    output logic      frame_n_i,   // frame select
    output logic      din_i        // resolved data-in level
);
    logic hb_r = 1'b0;
    logic hen_r = 1'b0;
    // a released line shows the inverse so a stale bit cannot pass
    assign din_i = !din_oe_n_o ? din_o : (hen_r ? hb_r : ~hb_r);
    initial begin
        link_sclk_i = 1'b1;
        frame_n_i = 1'b1;
    end
    task automatic idle(input int n); // frame high gap with clock edges
        repeat (n) begin
            #32 link_sclk_i = 1'b0;
            #32 link_sclk_i = 1'b1;
        end
    endtask
    task automatic xfer(input logic [15:0] wr, output logic [15:0] rd,
                        output logic st);
        // clock edges ahead of the frame let the offered word cross over
        idle(2);
        #16 frame_n_i = 1'b0;
        #16;
        for (int i = 15; i >= -2; i--) begin
            link_sclk_i = 1'b0;
            hen_r = (i >= 0); // host lets go before the device turns the line
            if (i >= 0) hb_r = wr[i];
            #32 link_sclk_i = 1'b1;
            if (i >= 0) rd[i] = dout_o;
            #16;
            if (i == -1) st = din_i;
            #16;
        end
        frame_n_i = 1'b1;
        idle(2);
    endtask
endmodule

// file: tb/adc_convert_calibrate_serial_timing_tb.sv
`timescale 1ns/1ns
module adc_convert_calibrate_serial_timing_tb;
    import acs_pkg::*;
    logic core_clk_i = 1'b0, rst_i = 1'b1, start_n = 1'b1, cal_n = 1'b1;
    logic [1:0] cal_sel = 2'h0;
    logic [13:0] sample = 14'h0;
    logic busy, refused, pdown, sclk, frame_n, din, din_o, din_oe_n, dout;
    logic din_shared = 1'b1, dout_oe_n;
    acs_pmode_t pmode;
    int error_cnt = 0, check_count = 0;
    always #10 core_clk_i = ~core_clk_i;
    acs_ctrl #(.CAL_FULL_CYC(40), .CAL_DACFS_CYC(30), .CAL_OFFS_CYC(20)) dut_u (
        .core_clk_i, .rst_i, .conversion_start_n_i(start_n), .cal_n_i(cal_n),
        .cal_sel_i(cal_sel), .sample_i(sample), .din_shared_i(din_shared),
        .busy_o(busy), .conv_refused_o(refused), .power_mode_o(pmode),
        .power_down_o(pdown), .link_sclk_i(sclk), .frame_n_i(frame_n),
        .din_i(din), .din_o(din_o), .din_oe_n_o(din_oe_n), .dout_o(dout),
        .dout_oe_n_o(dout_oe_n));
    acs_host_model host_u (.din_o(din_o), .din_oe_n_o(din_oe_n),
        .dout_o(dout), .link_sclk_i(sclk), .frame_n_i(frame_n), .din_i(din));
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #2;
    endtask
    // pin low for 5 cycles (100 ns), then count busy cycles
    task automatic run(input logic cal, output int n, output int r,
                       output logic rf);
        n = 0; r = 99; rf = 1'b0;
        if (cal) cal_n = 1'b0; else start_n = 1'b0;
        for (int w = 0; w < 300 && (n == 0 || busy === 1'b1); w++) begin
            tick(1);
            if (w == 4) begin cal_n = 1'b1; start_n = 1'b1; end
            if (busy === 1'b1 && n == 0) r = w;
            if (busy === 1'b1) n++;
            if (refused === 1'b1) rf = 1'b1;
        end
        tick(3);
    endtask
    task automatic rd_chk(input logic [15:0] wr, input logic [15:0] exp,
                          input logic est);
        logic [15:0] rd;
        logic st;
        host_u.xfer(wr, rd, st);
        chk(rd, exp);
        chk(st, est);
        tick(6);
    endtask
    task automatic t_conv_fifo;
        int n, r;
        logic rf;
        sample = 14'h2A5C; run(1'b0, n, r, rf);
        chk(n, 21);
        chk(r <= 2, 1'b1);
        sample = 14'h1FFF; run(1'b0, n, r, rf);
        sample = 14'h0001; run(1'b0, n, r, rf);
        chk({n != 0, rf}, 2'h2);
        // one word waits in the hand-off register, two in the buffer
        sample = 14'h0002; run(1'b0, n, r, rf);
        chk({n != 0, rf}, 2'h1);
        rd_chk(16'h0000, {14'h2A5C, 2'h0}, 1'b1);
        rd_chk(16'h0000, {14'h1FFF, 2'h0}, 1'b1);
        rd_chk(16'h0000, {14'h0001, 2'h0}, 1'b1);
        rd_chk(16'h0000, 16'h0000, 1'b0);
        // no sharing: line stays released and shows the inverse of bit 0
        din_shared = 1'b0;
        rd_chk(16'h0000, 16'h0000, 1'b1);
        din_shared = 1'b1;
        chk(dout_oe_n, 1'b1);
    endtask
    task automatic t_cal;
        int n, r;
        logic rf;
        int len [4] = '{40, 30, 20, 40};
        for (int s = 0; s < 4; s++) begin
            cal_sel = s[1:0]; run(1'b1, n, r, rf);
            chk(n, len[s] + 1);
            chk(r <= 2, 1'b1);
        end
        // start pulse inside an offset calibration must not cut or extend it
        cal_sel = 2'h2;
        cal_n = 1'b0;
        tick(4);
        start_n = 1'b0;
        cal_n = 1'b1;
        tick(5);
        start_n = 1'b1;
        for (n = 9; busy === 1'b1 && n < 300; n++) tick(1);
        chk(n, 20 + 3);
        tick(6);
        chk(busy, 1'b0);
    endtask
    task automatic t_pd;
        int n, r;
        logic rf;
        rd_chk(16'h0002, 16'h0000, 1'b0);
        chk({pmode, pdown}, 3'h5);
        run(1'b0, n, r, rf);
        chk(n, 0);
        rd_chk(16'h0003, 16'h0000, 1'b0);
        chk({pmode, pdown}, 3'h7);
        rd_chk(16'h0000, 16'h0000, 1'b0);
        chk({pmode, pdown}, 3'h0);
        sample = 14'h3C3C; run(1'b0, n, r, rf);
        chk(n, 21);
        rd_chk(16'h0000, {14'h3C3C, 2'h0}, 1'b1);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #2;
        host_u.idle(4);
        tick(2);
        rst_i = 1'b0;
        // the link leaves reset only on serial clock edges
        host_u.idle(3);
        tick(2);
        chk({busy, refused, pmode}, 4'h0);
        t_conv_fifo();
        t_cal();
        t_pd();
        summarize();
    end
    initial begin
        #500000;
        error_cnt++;
        summarize();
    end
endmodule
